// ---- logic/fbc_pkg.sv ----
// Shared constants and types for the four-bit sequencer and flag block
package fbc_pkg;

  localparam int          PC_W         = 10;
  localparam int          AXI_AW       = 8;
  localparam int          DMEM_DEPTH   = 32;
  localparam int          DMEM_AW      = 5;
  localparam int          CMD_W        = 17;
  localparam int          SYNC_W       = 6;

  localparam logic [9:0]  PC_RESET     = 10'h000;
  localparam logic [9:0]  TEST_LO      = 10'h3ea;
  localparam logic [9:0]  TEST_HI      = 10'h3ff;
  localparam logic [9:0]  PTR_RESET    = 10'h000;
  localparam logic [3:0]  ACC_FULL     = 4'hf;
  localparam logic [7:0]  CTRL0_RESET  = 8'h03;
  localparam int          CTRL0_PTR_LO = 4;
  localparam int          CTRL0_PTR_HI = 5;
  localparam logic [4:0]  FIRST_PAIR   = 5'h00;
  localparam logic [4:0]  LAST_PAIR    = 5'h1e;
  localparam logic [4:0]  LAST_WORD    = 5'h1f;

  // Status-test selector codes in operand bits 2..0, and the bit index of the special-pin enable
  localparam logic [2:0]  ST_KEY_A     = 3'h0;
  localparam logic [2:0]  ST_KEY_B     = 3'h3;
  localparam logic [2:0]  ST_KEY_C     = 3'h6;
  localparam logic [2:0]  ST_TIMER     = 3'h5;
  localparam int          ST_SPECIAL   = 3;

  // Register byte offsets
  localparam logic [7:0]  OFF_CMD      = 8'h00;
  localparam logic [7:0]  OFF_STATUS   = 8'h04;
  localparam logic [7:0]  OFF_CTRL0    = 8'h08;
  localparam logic [7:0]  OFF_RET      = 8'h0c;
  localparam logic [7:0]  OFF_PTR      = 8'h10;
  localparam logic [7:0]  OFF_DADDR    = 8'h14;
  localparam logic [7:0]  OFF_DDATA    = 8'h18;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [4:0] {
    OP_ORD, OP_JMP, OP_JC, OP_JNC, OP_JF, OP_JNF, OP_CALL, OP_RET,
    OP_STATUS_TEST_OP, OP_HALT, OP_ANL, OP_XRL, OP_ORL, OP_RL, OP_RLZ,
    OP_INC, OP_CARRY_ADJUST_ADD_OP, OP_MOV, OP_IN
  } fbc_op_t;

  typedef struct packed {
    logic [1:0] len;
    fbc_op_t    op;
    logic [9:0] operand;
  } fbc_cmd_t;

  typedef struct packed {
    logic [3:0] keys;
    logic       special_zero;
    logic       special_one;
  } fbc_pins_t;

endpackage

// ---- logic/fbc_data_mem.sv ----
// Data memory of four-bit words with byte-pair writes and registered read
`timescale 1ns/10ps
module fbc_data_mem #(
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          wr_en,
  input  wire logic          wr_pair,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [3:0]    rd_data,
  output logic      [7:0]    first_pair,
  output logic      [7:0]    last_pair
);
  logic [3:0] mem [DEPTH];
  logic [AW-1:0] even_addr;
  logic [AW-1:0] odd_addr;

  if (DEPTH < 4 || (DEPTH % 2) != 0 || (1 << AW) != DEPTH) begin : g_bad_size
    $error("fbc_data_mem: depth must be an even power of two matching AW");
  end

  assign even_addr  = {wr_addr[AW-1:1], 1'b0};
  assign odd_addr   = {wr_addr[AW-1:1], 1'b1};
  assign first_pair = {mem[1], mem[0]};
  assign last_pair  = {mem[DEPTH-1], mem[DEPTH-2]};

  // Only the first pair clears; the rest keeps its contents over reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem[0] <= 4'h0;
      mem[1] <= 4'h0;
    end else if (wr_en && wr_pair) begin
      mem[even_addr] <= wr_data[3:0];
      mem[odd_addr]  <= wr_data[7:4];
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data[3:0];
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

// ---- logic/fbc_sequencer.sv ----
// Program sequencing, stack, accumulator and flag logic behind AXI4-Lite
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module fbc_sequencer (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [fbc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [fbc_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic [3:0]             key_input_pins,
  input  wire logic                   special_input_zero,
  input  wire logic                   special_input_one,
  input  wire logic                   timer_zero,
  output logic [fbc_pkg::PC_W-1:0]    program_counter,
  output logic [fbc_pkg::PC_W-1:0]    rom_table_pointer,
  output logic                        standby,
  output logic                        system_reset
);
  import fbc_pkg::*;

  // Pin synchronisers
  fbc_pins_t      pin_meta_q;
  fbc_pins_t      pin_sync_q;

  // Bus slave state
  logic                aw_have_q;
  logic [AXI_AW-1:0]   aw_addr_q;
  logic                w_have_q;
  logic [31:0]         w_data_q;
  logic [3:0]          w_strb_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rpend_q;
  logic [AXI_AW-1:0]   raddr_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;

  // Core state
  logic [9:0]          pc_q, pc_d, pc_seq, pc_raw;
  logic                sp_q, sp_d;
  logic [1:0]          ret_hi_q;
  logic                ret_known_q;
  logic                carry_q, carry_d;
  logic                status_q, status_d;
  logic [3:0]          acc_q, acc_d;
  logic                standby_q, standby_d;
  logic [3:0]          halt_sel_q, halt_sel_d;
  logic                sysrst_q;
  logic [7:0]          ctrl0_q;
  logic [9:0]          ptr_q, ptr_d;
  logic [DMEM_AW-1:0]  daddr_q;
  logic [CMD_W-1:0]    last_cmd_q;
  logic                ovf, ret_wr;

  // Decode wires
  fbc_cmd_t            cmd;
  logic                wr_go, rd_go, int_rst;
  logic                sel_cmd, sel_ctrl0, sel_daddr, sel_ddata, sel_ro;
  logic                exec, wr_ddata, wr_ctrl0, wr_daddr;
  logic                test_hit, wake_hit, last_touch;
  logic [31:0]         status_word;
  logic [31:0]         rd_mux;
  logic [1:0]          rd_resp;
  logic [7:0]          first_pair, last_pair;
  logic [3:0]          dmem_rd;
  logic                mem_we;
  logic [DMEM_AW-1:0]  mem_addr;
  logic [7:0]          mem_wdata;

  function automatic logic status_test_op_test(input logic [3:0] sel, input fbc_pins_t p,
                                     input logic tz);
    logic hit;
    hit = 1'b0;
    case (sel[2:0])
      ST_KEY_A, ST_KEY_B, ST_KEY_C: hit = |p.keys;
      ST_TIMER:                     hit = tz;
      default:                      hit = 1'b0;
    endcase
    if (sel[ST_SPECIAL]) begin
      hit = hit | p.special_zero | p.special_one;
    end
    return hit;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= '{keys: key_input_pins, special_zero: special_input_zero,
                      special_one: special_input_one};
      pin_sync_q <= pin_meta_q;
    end
  end

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_go         = aw_have_q && w_have_q && !bvalid_q;

  assign sel_cmd   = aw_addr_q[7:2] == OFF_CMD[7:2];
  assign sel_ctrl0 = aw_addr_q[7:2] == OFF_CTRL0[7:2];
  assign sel_daddr = aw_addr_q[7:2] == OFF_DADDR[7:2];
  assign sel_ddata = aw_addr_q[7:2] == OFF_DDATA[7:2];
  assign sel_ro    = aw_addr_q[7:2] == OFF_STATUS[7:2] || aw_addr_q[7:2] == OFF_RET[7:2]
                  || aw_addr_q[7:2] == OFF_PTR[7:2];

  assign cmd       = fbc_cmd_t'(w_data_q[CMD_W-1:0]);
  // Commands are dropped while asleep or during the internal reset cycle
  assign exec      = wr_go && sel_cmd && (&w_strb_q[2:0]) && !standby_q && !sysrst_q;
  assign wr_ctrl0  = wr_go && sel_ctrl0 && w_strb_q[0];
  assign wr_daddr  = wr_go && sel_daddr && w_strb_q[0];
  assign wr_ddata  = wr_go && sel_ddata && w_strb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q  <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (sel_cmd || sel_ctrl0 || sel_daddr || sel_ddata || sel_ro)
                     ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel: one wait cycle lets the memory read register settle
  assign s_axi_arready = !rpend_q && !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign rd_go         = s_axi_arvalid && s_axi_arready;

  assign status_word = {13'h0000, ret_known_q, acc_q, standby_q, status_q, carry_q,
                        sp_q, pc_q};

  always_comb begin
    rd_resp = RESP_OKAY;
    if (raddr_q[7:2] == OFF_CMD[7:2]) begin
      rd_mux = {15'h0000, last_cmd_q};
    end else if (raddr_q[7:2] == OFF_STATUS[7:2]) begin
      rd_mux = status_word;
    end else if (raddr_q[7:2] == OFF_CTRL0[7:2]) begin
      rd_mux = {24'h000000, ctrl0_q};
    end else if (raddr_q[7:2] == OFF_RET[7:2]) begin
      rd_mux = {22'h000000, ret_hi_q, last_pair};
    end else if (raddr_q[7:2] == OFF_PTR[7:2]) begin
      rd_mux = {22'h000000, ptr_q};
    end else if (raddr_q[7:2] == OFF_DADDR[7:2]) begin
      rd_mux = {27'h0000000, daddr_q};
    end else if (raddr_q[7:2] == OFF_DDATA[7:2]) begin
      rd_mux = {28'h0000000, dmem_rd};
    end else begin
      rd_mux  = 32'h00000000;
      rd_resp = RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rpend_q  <= 1'b0;
      raddr_q  <= '0;
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else begin
      if (rd_go) begin
        rpend_q <= 1'b1;
        raddr_q <= s_axi_araddr;
      end
      if (rpend_q) begin
        rpend_q  <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= rd_resp;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Core next state
  assign int_rst  = !aresetn || sysrst_q;
  assign test_hit = status_test_op_test(cmd.operand[3:0], pin_sync_q, timer_zero);
  assign wake_hit = status_test_op_test(halt_sel_q, pin_sync_q, timer_zero);
  assign pc_seq   = pc_q + {8'h00, cmd.len};
  assign ptr_d    = {ctrl0_q[CTRL0_PTR_HI:CTRL0_PTR_LO], first_pair};

  always_comb begin
    pc_raw     = pc_q;
    sp_d       = sp_q;
    carry_d    = carry_q;
    status_d   = status_q;
    acc_d      = acc_q;
    standby_d  = standby_q;
    halt_sel_d = halt_sel_q;
    ovf        = 1'b0;
    ret_wr     = 1'b0;
    if (exec) begin
      pc_raw = pc_seq;
      case (cmd.op)
        OP_JMP: pc_raw = cmd.operand;
        OP_JC:  if (carry_q) pc_raw = cmd.operand;
        OP_JNC: if (!carry_q) pc_raw = cmd.operand;
        OP_JF:  if (status_q) pc_raw = cmd.operand;
        OP_JNF: if (!status_q) pc_raw = cmd.operand;
        OP_CALL: begin
          if (sp_q) begin
            ovf = 1'b1;
          end else begin
            ret_wr = 1'b1;
            sp_d   = 1'b1;
            pc_raw = cmd.operand;
          end
        end
        OP_RET: begin
          if (!sp_q) begin
            ovf = 1'b1;
          end else begin
            sp_d   = 1'b0;
            pc_raw = {ret_hi_q, last_pair};
          end
        end
        OP_STATUS_TEST_OP: status_d = test_hit;
        OP_HALT: begin
          if (test_hit) begin
            status_d = 1'b1;
          end else if (status_q) begin
            status_d = 1'b0;
          end else begin
            standby_d  = 1'b1;
            halt_sel_d = cmd.operand[3:0];
          end
        end
        OP_ANL: begin
          acc_d   = acc_q & cmd.operand[3:0];
          carry_d = acc_q[3] & cmd.operand[3];
        end
        OP_XRL: begin
          acc_d   = acc_q ^ cmd.operand[3:0];
          carry_d = acc_q[3] & cmd.operand[3];
        end
        OP_ORL: begin
          acc_d   = acc_q | cmd.operand[3:0];
          carry_d = 1'b0;
        end
        OP_RL: begin
          acc_d   = {acc_q[2:0], acc_q[3]};
          carry_d = acc_q[3];
        end
        OP_RLZ: begin
          acc_d   = {acc_q[2:0], 1'b0};
          carry_d = acc_q[3];
        end
        OP_INC: begin
          acc_d   = acc_q + 4'h1;
          carry_d = acc_q == ACC_FULL;
        end
        OP_CARRY_ADJUST_ADD_OP: begin
          acc_d   = acc_q + {3'h0, carry_q};
          carry_d = acc_q == ACC_FULL;
        end
        OP_MOV: begin
          acc_d   = cmd.operand[3:0];
          carry_d = 1'b0;
        end
        OP_IN: begin
          acc_d   = pin_sync_q.keys;
          carry_d = 1'b0;
        end
        default: ;
      endcase
    end else if (standby_q && wake_hit) begin
      standby_d = 1'b0;
      status_d  = 1'b1;
    end
    // Test area traps straight back to the start
    pc_d = (pc_raw >= TEST_LO && pc_raw <= TEST_HI) ? PC_RESET : pc_raw;
  end

  always_ff @(posedge aclk) begin
    if (int_rst) begin
      pc_q       <= PC_RESET;
      sp_q       <= 1'b0;
      carry_q    <= 1'b0;
      status_q   <= 1'b0;
      standby_q  <= 1'b0;
      halt_sel_q <= 4'h0;
      ctrl0_q    <= CTRL0_RESET;
      ptr_q      <= PTR_RESET;
    end else begin
      pc_q       <= pc_d;
      sp_q       <= sp_d;
      carry_q    <= carry_d;
      status_q   <= status_d;
      standby_q  <= standby_d;
      halt_sel_q <= halt_sel_d;
      ctrl0_q    <= wr_ctrl0 ? w_data_q[7:0] : ctrl0_q;
      ptr_q      <= ptr_d;
    end
  end

  // Accumulator and upper return bits deliberately ride through reset
  always_ff @(posedge aclk) begin
    acc_q <= acc_d;
    if (ret_wr) begin
      ret_hi_q <= pc_seq[9:8];
    end
  end

  assign last_touch = (wr_ddata && daddr_q[DMEM_AW-1:1] == LAST_PAIR[DMEM_AW-1:1])
                   || (rpend_q && raddr_q[7:2] == OFF_DDATA[7:2]
                       && daddr_q[DMEM_AW-1:1] == LAST_WORD[DMEM_AW-1:1]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sysrst_q    <= 1'b0;
      ret_known_q <= 1'b0;
      daddr_q     <= '0;
      last_cmd_q  <= '0;
    end else begin
      sysrst_q <= ovf;
      if (ret_wr) begin
        ret_known_q <= 1'b1;
      end else if (last_touch) begin
        ret_known_q <= 1'b0;
      end
      if (wr_daddr) begin
        daddr_q <= w_data_q[DMEM_AW-1:0];
      end
      if (exec) begin
        last_cmd_q <= w_data_q[CMD_W-1:0];
      end
    end
  end

  // Call writes the return low byte as one pair; software writes single words
  assign mem_we    = ret_wr || wr_ddata;
  assign mem_addr  = ret_wr ? LAST_PAIR : daddr_q;
  assign mem_wdata = ret_wr ? pc_seq[7:0] : {4'h0, w_data_q[3:0]};

  fbc_data_mem #(
    .DEPTH (DMEM_DEPTH),
    .AW    (DMEM_AW)
  ) u_dmem (
    .clk        (aclk),
    .rst_n      (!int_rst),
    .wr_en      (mem_we),
    .wr_pair    (ret_wr),
    .wr_addr    (mem_addr),
    .wr_data    (mem_wdata),
    .rd_addr    (daddr_q),
    .rd_data    (dmem_rd),
    .first_pair (first_pair),
    .last_pair  (last_pair)
  );

  assign program_counter   = pc_q;
  assign rom_table_pointer = ptr_q;
  assign standby           = standby_q;
  assign system_reset      = sysrst_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ovf_resets: assert property ((exec && cmd.op == OP_CALL && sp_q) |=> sysrst_q ##1
    (pc_q == PC_RESET && !sp_q)) else $error("overflow did not reset core");
  a_undf_resets: assert property ((exec && cmd.op == OP_RET && !sp_q) |=> sysrst_q)
    else $error("underflow did not raise reset");
  a_jump_load: assert property ((exec && cmd.op == OP_JMP && cmd.operand < TEST_LO)
    |=> pc_q == $past(cmd.operand)) else $error("jump target not loaded");
  a_seq_step: assert property ((exec && cmd.op == OP_ORD && pc_seq < TEST_LO)
    |=> pc_q == $past(pc_q) + {8'h00, $past(cmd.len)}) else $error("pc did not advance");
  a_call_ret_pair: assert property ((exec && cmd.op == OP_CALL && !sp_q)
    |=> sp_q && {ret_hi_q, last_pair} == $past(pc_seq)) else $error("return address lost");
  a_test_trap: assert property (pc_q < TEST_LO)
    else $error("pc entered test area");
  a_sp_only_calls: assert property ((!exec && !sysrst_q) |=> $stable(sp_q))
    else $error("stack pointer moved without call or return");
  a_carry_andxor: assert property ((exec && (cmd.op == OP_ANL || cmd.op == OP_XRL))
    |=> carry_q == ($past(acc_q[3]) & $past(cmd.operand[3]))) else $error("and carry wrong");
  a_carry_rotate: assert property ((exec && (cmd.op == OP_RL || cmd.op == OP_RLZ))
    |=> carry_q == $past(acc_q[3])) else $error("rotate carry wrong");
  a_carry_inc: assert property ((exec && (cmd.op == OP_INC || cmd.op == OP_CARRY_ADJUST_ADD_OP))
    |=> carry_q == ($past(acc_q) == ACC_FULL)) else $error("increment carry wrong");
  a_carry_clear: assert property ((exec && (cmd.op == OP_ORL || cmd.op == OP_MOV
    || cmd.op == OP_IN)) |=> !carry_q) else $error("carry not cleared");
  a_status_test: assert property ((exec && cmd.op == OP_STATUS_TEST_OP)
    |=> status_q == $past(test_hit)) else $error("status test wrong");
  a_ptr_follow: assert property (!sysrst_q |=> ptr_q == $past(ptr_d))
    else $error("table pointer stale");

  c_call_return: cover property ((exec && cmd.op == OP_CALL && !sp_q) ##[1:50]
    (exec && cmd.op == OP_RET && sp_q));
  c_overflow: cover property (sysrst_q);
  c_standby_exit: cover property (standby_q ##[1:100] !standby_q && status_q);
endmodule

// ---- testbench/four_bit_cpu_sequencer_flags_tb.sv ----
// Self-checking bench for the four-bit sequencer and flag block
`timescale 1ns/10ps
module four_bit_cpu_sequencer_flags_tb;
  import fbc_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [3:0]  keys = 4'h0;
  logic [1:0]  spec = 2'h0, bresp, rresp, r;
  logic        tz = 1'b0, awready, wready, bvalid, arready, rvalid, stby, srst;
  logic [9:0]  pc, ptr;
  int          n_mismatch = 0, comparisons = 0, n_rst = 0;

  // Byte strobes stay full; partial strobes drop commands, but byte-0 strobe alone still writes CTRL0, DADDR and DDATA
  fbc_sequencer fbc_sequencer_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .key_input_pins(keys), .special_input_zero(spec[1]), .special_input_one(spec[0]),
    .timer_zero(tz), .program_counter(pc), .rom_table_pointer(ptr), .standby(stby),
    .system_reset(srst)
  );

  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) if (srst === 1'b1) n_rst++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Waits for the answer; only the watchdog ends a hang
    forever begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        break;
      end
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        v = rdata;
        r = rresp;
        break;
      end
    end
    rready <= 1'b0;
  endtask

  task automatic cmd(input logic [1:0] l, input fbc_op_t op, input logic [9:0] o);
    wr(OFF_CMD, {15'h0, l, op, o});
  endtask

  task automatic t_reset();
    chk(32'({pc, ptr, stby, srst}), 32'h0);
    rd(OFF_STATUS);
    chk(32'(v[13:10]), 32'h0);
    rd(OFF_CTRL0);
    chk(v, 32'h03);
    rd(8'h40);
    chk(v, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(8'h40, 32'h1);
    chk(32'(r), 32'(RESP_SLVERR));
  endtask

  task automatic t_jump();
    fbc_op_t    ops [6] = '{OP_ORD, OP_JMP, OP_JC, OP_JNC, OP_JF, OP_JNF};
    logic [9:0] dst [6] = '{10'h3ff, 10'h155, 10'h100, 10'h120, 10'h130, 10'h140};
    logic [9:0] exp [6] = '{10'h002, 10'h155, 10'h156, 10'h120, 10'h121, 10'h140};
    for (int i = 0; i < 6; i++) begin
      cmd((i == 0) ? 2'h2 : 2'h1, ops[i], dst[i]);
      chk(32'(pc), 32'(exp[i]));
    end
  endtask

  task automatic t_call();
    int b;
    cmd(2'h2, OP_CALL, 10'h200);
    rd(OFF_STATUS);
    chk(32'(v[10:0]), 32'h600);
    chk(32'(v[18]), 32'h1);
    cmd(2'h1, OP_RET, 10'h0);
    chk(32'(pc), 32'h142);
    cmd(2'h2, OP_CALL, 10'h200);
    b = n_rst;
    cmd(2'h1, OP_CALL, 10'h300);
    repeat (4) @(posedge aclk);
    chk(32'({n_rst, pc}), 32'({b + 1, 10'h0}));
    rd(OFF_RET);
    chk(32'(v[9:0]), 32'h144);
    cmd(2'h1, OP_RET, 10'h0);
    repeat (4) @(posedge aclk);
    rd(OFF_STATUS);
    chk(32'({n_rst, v[10:0]}), 32'({b + 2, 11'h0}));
  endtask

  task automatic t_fetch();
    cmd(2'h1, OP_JMP, 10'h3e9);
    chk(32'(pc), 32'h3e9);
    cmd(2'h1, OP_ORD, 10'h0);
    chk(32'(pc), 32'h0);
  endtask

  task automatic t_flags();
    fbc_op_t    ops [13] = '{OP_MOV, OP_ANL, OP_ORL, OP_XRL, OP_RL, OP_MOV, OP_RLZ,
                             OP_MOV, OP_INC, OP_INC, OP_MOV, OP_CARRY_ADJUST_ADD_OP, OP_IN};
    logic [3:0] opd [13] = '{8, 8, 0, 8, 0, 15, 0, 15, 0, 0, 15, 0, 0};
    logic       cy  [13] = '{0, 1, 0, 1, 0, 0, 1, 0, 1, 0, 0, 1, 0};
    for (int i = 0; i < 13; i++) begin
      cmd(2'h1, ops[i], {6'h0, opd[i]});
      rd(OFF_STATUS);
      chk(32'(v[11]), 32'(cy[i]));
      if (ops[i] == OP_MOV) chk(32'(v[17:14]), 32'(opd[i]));
    end
  endtask

  task automatic sts(input logic [3:0] k, input logic [1:0] s, input logic t,
                     input fbc_op_t op, input logic [9:0] o, input logic [1:0] e);
    keys <= k;
    spec <= s;
    tz <= t;
    repeat (4) @(posedge aclk);
    cmd(2'h1, op, o);
    rd(OFF_STATUS);
    chk(32'(v[13:12]), 32'(e));
  endtask

  task automatic t_status();
    sts(4'h1, 2'h0, 1'b0, OP_STATUS_TEST_OP, 10'h0, 2'h1);
    sts(4'h0, 2'h0, 1'b0, OP_STATUS_TEST_OP, 10'h3, 2'h0);
    sts(4'h8, 2'h0, 1'b0, OP_STATUS_TEST_OP, 10'h6, 2'h1);
    sts(4'h0, 2'h0, 1'b1, OP_STATUS_TEST_OP, 10'h5, 2'h1);
    sts(4'h0, 2'h2, 1'b0, OP_STATUS_TEST_OP, 10'hd, 2'h1);
    sts(4'h0, 2'h1, 1'b0, OP_STATUS_TEST_OP, 10'h5, 2'h0);
    sts(4'h0, 2'h1, 1'b0, OP_STATUS_TEST_OP, 10'hb, 2'h1);
    sts(4'h2, 2'h0, 1'b0, OP_HALT, 10'h0, 2'h1);
    sts(4'h0, 2'h0, 1'b0, OP_HALT, 10'h0, 2'h0);
    sts(4'h0, 2'h0, 1'b0, OP_HALT, 10'h0, 2'h2);
    keys <= 4'h4;
    repeat (6) @(posedge aclk);
    rd(OFF_STATUS);
    chk(32'({stby, v[13:12]}), 32'h1);
  endtask

  task automatic t_ptr();
    wr(OFF_CTRL0, 32'h33);
    wr(OFF_DADDR, 32'h0);
    wr(OFF_DDATA, 32'h5);
    wr(OFF_DADDR, 32'h1);
    wr(OFF_DDATA, 32'ha);
    wr(OFF_DADDR, 32'h2);
    wr(OFF_DDATA, 32'h7);
    rd(OFF_PTR);
    chk({v[31:10], ptr}, 32'h3a5);
    chk(v, 32'h3a5);
    // Underflow, like a call with the stack already full, pulls the internal reset
    cmd(2'h1, OP_RET, 10'h0);
    repeat (4) @(posedge aclk);
    chk(32'(ptr), 32'h0);
    rd(OFF_DDATA);
    chk(v, 32'h7);
    wr(OFF_DADDR, 32'h0);
    rd(OFF_DDATA);
    chk(v, 32'h0);
    // Touching the shared last word as data clears the return-known flag
    wr(OFF_DADDR, 32'h1f);
    rd(OFF_DDATA);
    rd(OFF_STATUS);
    chk(32'(v[18]), 32'h0);
  endtask

  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_jump();
    t_call();
    t_fetch();
    t_flags();
    t_status();
    t_ptr();
    end_of_test();
  end
endmodule
